// [common/itsf_pkg.sv]
// Types shared by the status flag block
package itsf_pkg;

	// APB request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} itsf_apb_type;

	// One-cycle event pulses from the shift engine
	typedef struct packed {
		logic startSent;
		logic stopSent;
		logic addrAcked;
		logic addrMatch;
		logic headerSent;
		logic stopSeen;
		logic arbLost;
		logic busErr;
		logic ackMissing;
		logic pecMismatch;
		logic alertAddrRcvd;
		logic alertSeen;
		logic rxByteDone;
		logic txShiftDone;
	} itsf_evt_type;

	// Bus levels seen by the shift engine
	typedef struct packed {
		logic sclLow;
		logic alertLineLow;
		logic isMaster;
		logic isTransmitter;
		logic busBusy;
	} itsf_line_type;

endpackage : itsf_pkg

// [common/itsf_regs.svh]
// Register map, field positions and timing counts of the status flags
//
// Overview of operation
// - Alert flag set by alert events; write 0 clears
// - SMBus clock low 25 ms sets timeout
// - Checksum mismatch sets flag and forces NACK
// - No stretch, receiving unread byte: overrun
// - No stretch, transmit empty register: underrun
// - Missing acknowledge sets sticky ack error
// - Arbitration loss sets flag, back to slave
// - Misplaced START or STOP sets bus error
// - Byte to shifter sets empty; write clears
// - Both empty: write keeps empty flag set
// - Byte to data register sets full; read clears
// - Full plus complete: read keeps full set
// - Slave STOP flag; status read, control write
// - Header flag; status read, data write clears
// - Stretching: complete flag on stalled byte
// - Complete cleared by sequence, START/STOP, disable
// - Address flag; status then second status read
// - Start flag; status read, data write clears
// - Error interrupt on any error flag
// - Event interrupt; buffer flags need buffer enable
`ifndef ITSF_REGS_SVH
`define ITSF_REGS_SVH

// ----------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------
`define ITSF_CTL0_OFS 8'h00
`define ITSF_CTL1_OFS 8'h04
`define ITSF_DATA_OFS 8'h10
`define ITSF_STAT0_OFS 8'h14
`define ITSF_STAT1_OFS 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ITSF_C0_EN 0
`define ITSF_C0_SMB 1
`define ITSF_C0_HOST 3
`define ITSF_C0_NOSTR 7
`define ITSF_C0_ACK 10
`define ITSF_C1_ERROR_IRQ_ENABLE 8
`define ITSF_C1_EVENT_IRQ_ENABLE 9
`define ITSF_C1_BUFFER_IRQ_ENABLE 10
`define ITSF_S0_ALT 15
`define ITSF_S0_TO 14
`define ITSF_S0_PEC 12
`define ITSF_S0_OU 11
`define ITSF_S0_ACK_ERROR_FLAG 10
`define ITSF_S0_ARB 9
`define ITSF_S0_BUS_ERROR_FLAG 8
`define ITSF_S0_TBE 7
`define ITSF_S0_RBF 6
`define ITSF_S0_STP 4
`define ITSF_S0_HDR 3
`define ITSF_S0_BTC 2
`define ITSF_S0_ADR 1
`define ITSF_S0_SB 0
`define ITSF_S1_MST 0
`define ITSF_S1_BSY 1
`define ITSF_S1_TR 2

// ----------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------
`define ITSF_CTL0_MASK 16'h048B
`define ITSF_CTL1_MASK 16'h0700
`define ITSF_CTL_RST 16'h0000
`define ITSF_W0C_MASK 16'hDF00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ITSF_TIMEOUT_MS 25
`define ITSF_CLK_KHZ 50000
`define ITSF_TO_W 21

`endif

// [design/itsf_status.sv]
// APB-reached status flag logic of a two-wire bus controller
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "itsf_regs.svh"

module itsf_status #(
	parameter int TIMEOUT_CYCLES = `ITSF_TIMEOUT_MS * `ITSF_CLK_KHZ
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// APB slave
	input itsf_pkg::itsf_apb_type apb,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	// Shift engine
	input itsf_pkg::itsf_evt_type evt,
	input itsf_pkg::itsf_line_type lines,
	input wire logic [7:0] rxByte,
	output logic [7:0] txByte,
	output logic txLoad,
	output logic ackEnable,
	output logic forceNack,
	output logic toSlave,
	output logic periphEnable,
	// Interrupts
	output logic errIrq,
	output logic evIrq
);
	import itsf_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [15:0] ctl0;
		logic [15:0] ctl1;
		logic [15:0] stat;
		logic [7:0] dataReg;
		logic dataFull;
		logic [7:0] shiftByte;
		logic shiftFull;
		logic txBusy;
		logic statRead;
		logic [`ITSF_TO_W-1:0] toCnt;
		logic [7:0] txByte;
		logic txLoad;
		logic forceNack;
		logic toSlave;
		logic errIrq;
		logic evIrq;
	} itsf_state_type;

	itsf_state_type st_r;
	itsf_state_type st_nxt;

	logic setup;
	logic access;
	logic wr;
	logic rd;
	logic mapped;
	logic noStretch;
	logic [15:0] s;

	// Setup and completing access phase; slave answers with no wait
	assign setup = apb.psel & ~apb.penable;
	assign access = apb.psel & apb.penable & st_r.pready;
	assign wr = access & apb.pwrite;
	assign rd = access & ~apb.pwrite;
	assign noStretch = st_r.ctl0[`ITSF_C0_NOSTR];
	assign mapped = (apb.paddr == `ITSF_CTL0_OFS) ||
		(apb.paddr == `ITSF_CTL1_OFS) ||
		(apb.paddr == `ITSF_DATA_OFS) ||
		(apb.paddr == `ITSF_STAT0_OFS) ||
		(apb.paddr == `ITSF_STAT1_OFS);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		s = st_r.stat;
		st_nxt.txLoad = 1'b0;
		st_nxt.toSlave = 1'b0;
		st_nxt.pready = setup;
		st_nxt.pslverr = setup & ~mapped;

		// Read data latched at setup, held through the access phase
		if (setup) begin
			st_nxt.prdata = 32'h0000_0000;
			case (apb.paddr)
				`ITSF_CTL0_OFS: st_nxt.prdata[15:0] = st_r.ctl0;
				`ITSF_CTL1_OFS: st_nxt.prdata[15:0] = st_r.ctl1;
				`ITSF_DATA_OFS: st_nxt.prdata[7:0] = st_r.dataReg;
				`ITSF_STAT0_OFS: st_nxt.prdata[15:0] = st_r.stat;
				`ITSF_STAT1_OFS: begin
					st_nxt.prdata[`ITSF_S1_MST] = lines.isMaster;
					st_nxt.prdata[`ITSF_S1_BSY] = lines.busBusy;
					st_nxt.prdata[`ITSF_S1_TR] = lines.isTransmitter;
				end
				default: st_nxt.prdata = 32'h0000_0000;
			endcase
		end

		// Software clears: write 0 clears, write 1 keeps
		if (wr && apb.paddr == `ITSF_STAT0_OFS) begin
			s = s & (apb.pwdata[15:0] | ~`ITSF_W0C_MASK);
		end
		if (wr && apb.paddr == `ITSF_CTL0_OFS) begin
			st_nxt.ctl0 = apb.pwdata[15:0] & `ITSF_CTL0_MASK;
			if (st_r.statRead) begin
				s[`ITSF_S0_STP] = 1'b0;
			end
		end
		if (wr && apb.paddr == `ITSF_CTL1_OFS) begin
			st_nxt.ctl1 = apb.pwdata[15:0] & `ITSF_CTL1_MASK;
		end

		// Read-sequence clears keyed on a prior status read
		if (access && apb.paddr == `ITSF_DATA_OFS && st_r.statRead) begin
			s[`ITSF_S0_BTC] = 1'b0;
			if (apb.pwrite) begin
				s[`ITSF_S0_HDR] = 1'b0;
				s[`ITSF_S0_SB] = 1'b0;
			end
		end
		if (rd && apb.paddr == `ITSF_STAT1_OFS && st_r.statRead) begin
			s[`ITSF_S0_ADR] = 1'b0;
		end
		if (access) begin
			st_nxt.statRead = ~apb.pwrite &&
				(apb.paddr == `ITSF_STAT0_OFS);
		end

		// Software writes the data register
		if (wr && apb.paddr == `ITSF_DATA_OFS) begin
			if (lines.isTransmitter && !st_r.txBusy && !st_r.dataFull) begin
				// Straight into the shifter, buffer stays empty
				st_nxt.txByte = apb.pwdata[7:0];
				st_nxt.txLoad = 1'b1;
				st_nxt.txBusy = 1'b1;
				s[`ITSF_S0_TBE] = 1'b1;
			end else begin
				st_nxt.dataReg = apb.pwdata[7:0];
				st_nxt.dataFull = 1'b1;
				s[`ITSF_S0_TBE] = 1'b0;
			end
		end

		// Software reads the data register
		if (rd && apb.paddr == `ITSF_DATA_OFS && !lines.isTransmitter) begin
			if (st_r.shiftFull) begin
				// Pending byte follows at once, full flag stays
				st_nxt.dataReg = st_r.shiftByte;
				st_nxt.shiftFull = 1'b0;
				s[`ITSF_S0_RBF] = 1'b1;
			end else begin
				st_nxt.dataFull = 1'b0;
				s[`ITSF_S0_RBF] = 1'b0;
			end
		end

		// Receive path; hardware set wins over a same-cycle clear
		if (evt.rxByteDone) begin
			if (!st_nxt.dataFull || !st_r.dataFull) begin
				st_nxt.dataReg = rxByte;
				st_nxt.dataFull = 1'b1;
				s[`ITSF_S0_RBF] = 1'b1;
			end else if (noStretch) begin
				s[`ITSF_S0_OU] = 1'b1;
			end else begin
				st_nxt.shiftByte = rxByte;
				st_nxt.shiftFull = 1'b1;
				s[`ITSF_S0_BTC] = 1'b1;
			end
		end

		// Transmit path: shifter drained, refill from data register
		if (evt.txShiftDone) begin
			st_nxt.txBusy = 1'b0;
			if (st_r.dataFull) begin
				st_nxt.txByte = st_r.dataReg;
				st_nxt.txLoad = 1'b1;
				st_nxt.txBusy = 1'b1;
				st_nxt.dataFull = 1'b0;
				s[`ITSF_S0_TBE] = 1'b1;
			end else if (noStretch) begin
				s[`ITSF_S0_OU] = 1'b1;
			end else begin
				s[`ITSF_S0_BTC] = 1'b1;
			end
		end

		// Hardware clears of the completion flag
		if (evt.startSent || evt.stopSent ||
			!st_r.ctl0[`ITSF_C0_EN]) begin
			s[`ITSF_S0_BTC] = 1'b0;
		end

		// Bus events
		if (evt.startSent && lines.isMaster) begin
			s[`ITSF_S0_SB] = 1'b1;
		end
		if ((evt.addrAcked && lines.isMaster) ||
			(evt.addrMatch && !lines.isMaster)) begin
			s[`ITSF_S0_ADR] = 1'b1;
		end
		if (evt.headerSent && lines.isMaster) begin
			s[`ITSF_S0_HDR] = 1'b1;
		end
		if (evt.stopSeen && !lines.isMaster) begin
			s[`ITSF_S0_STP] = 1'b1;
		end
		if (evt.arbLost) begin
			s[`ITSF_S0_ARB] = 1'b1;
			st_nxt.toSlave = 1'b1;
		end
		if (evt.busErr) begin
			s[`ITSF_S0_BUS_ERROR_FLAG] = 1'b1;
		end
		if (evt.ackMissing) begin
			s[`ITSF_S0_ACK_ERROR_FLAG] = 1'b1;
		end
		if (evt.pecMismatch) begin
			s[`ITSF_S0_PEC] = 1'b1;
		end
		// NACK forced until software clears the checksum error
		st_nxt.forceNack = evt.pecMismatch | s[`ITSF_S0_PEC];
		if ((st_r.ctl0[`ITSF_C0_HOST] && evt.alertSeen) ||
			(!st_r.ctl0[`ITSF_C0_HOST] && lines.alertLineLow &&
			evt.alertAddrRcvd)) begin
			s[`ITSF_S0_ALT] = 1'b1;
		end

		// Clock-low watchdog, fires once per low stretch
		if (st_r.ctl0[`ITSF_C0_SMB] && lines.sclLow) begin
			if (st_r.toCnt == `ITSF_TO_W'(TIMEOUT_CYCLES - 1)) begin
				s[`ITSF_S0_TO] = 1'b1;
			end
			if (st_r.toCnt != `ITSF_TO_W'(TIMEOUT_CYCLES)) begin
				st_nxt.toCnt = st_r.toCnt + `ITSF_TO_W'(1);
			end
		end else begin
			st_nxt.toCnt = '0;
		end

		// Interrupt lines
		st_nxt.errIrq = st_nxt.ctl1[`ITSF_C1_ERROR_IRQ_ENABLE] &&
			(|(s & `ITSF_W0C_MASK));
		st_nxt.evIrq = st_nxt.ctl1[`ITSF_C1_EVENT_IRQ_ENABLE] &&
			(s[`ITSF_S0_SB] || s[`ITSF_S0_ADR] || s[`ITSF_S0_HDR] ||
			s[`ITSF_S0_STP] || s[`ITSF_S0_BTC] ||
			(st_nxt.ctl1[`ITSF_C1_BUFFER_IRQ_ENABLE] &&
			(s[`ITSF_S0_TBE] || s[`ITSF_S0_RBF])));

		st_nxt.stat = s & (`ITSF_W0C_MASK | 16'h00DF);
	end

	// ----------------------------------------------------------------
	// Registers; enable low freezes everything
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= '0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flops
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign prdata = st_r.prdata;
	assign txByte = st_r.txByte;
	assign txLoad = st_r.txLoad;
	assign ackEnable = st_r.ctl0[`ITSF_C0_ACK];
	assign forceNack = st_r.forceNack;
	assign toSlave = st_r.toSlave;
	assign periphEnable = st_r.ctl0[`ITSF_C0_EN];
	assign errIrq = st_r.errIrq;
	assign evIrq = st_r.evIrq;

endmodule : itsf_status

// [tb/itsf_shift_model.sv]
// Behavioural shift engine and bus partners
`timescale 1ns/1ps
module itsf_shift_model (
	// Command from the bench
	input wire logic clk,
	input wire logic go,
	input wire logic [3:0] kind,
	input wire logic [7:0] rxIn,
	// Into the block
	output itsf_pkg::itsf_evt_type evt,
	output logic [7:0] rxByte
);
	import itsf_pkg::*;
	initial begin
		evt = '0;
		rxByte = 8'h5A;
	end
	// One pulse per command; index 0 is the top field
	always @(posedge clk) begin
		evt <= go ? itsf_evt_type'(14'h2000 >> kind) : '0;
		// Byte toggles outside its pulse so stale data never matches
		rxByte <= (go && kind == 4'hC) ? rxIn : ~rxByte;
	end
endmodule : itsf_shift_model

// [tb/itsf_status_asserts.sv]
// Port-level checks for the status flag block
`timescale 1ns/1ps
module itsf_status_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// Bus side
	input itsf_pkg::itsf_apb_type apb,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	// Engine side
	input itsf_pkg::itsf_evt_type evt,
	input wire logic txLoad,
	input wire logic ackEnable,
	input wire logic forceNack,
	input wire logic toSlave,
	input wire logic periphEnable
);
	import itsf_pkg::*;
	// ----
	// Checks, one domain
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Zero-wait answer, holes refused, reserved bits zero
	AST_READY: assert property (
		ce && apb.psel && !apb.penable |=> pready) else $error("no ready");
	AST_HOLE: assert property (
		pready |-> pslverr ==
		!(apb.paddr inside {8'h00, 8'h04, 8'h10, 8'h14, 8'h18}))
		else $error("bad refusal");
	AST_RSVD: assert property (
		pready && apb.paddr == 8'h14 |->
		prdata[31:16] == 16'h0000 && !prdata[13] && !prdata[5])
		else $error("reserved bit set");
	// Control bits follow the written word
	AST_EN: assert property (
		ce && pready && apb.pwrite && apb.paddr == 8'h00 |=>
		periphEnable == $past(apb.pwdata[0])) else $error("enable");
	AST_ACK: assert property (
		ce && pready && apb.pwrite && apb.paddr == 8'h00 |=>
		ackEnable == $past(apb.pwdata[10])) else $error("ack enable");
	// Engine reactions, a fixed cycle after their cause; shifter load a one-cycle pulse
	AST_NACK: assert property (
		ce && evt.pecMismatch |=> forceNack) else $error("no nack");
	AST_ARB: assert property (
		ce && evt.arbLost |=> toSlave ##1 !toSlave) else $error("slave");
	AST_LOAD: assert property (
		txLoad |=> !txLoad) else $error("load not a pulse");
endmodule : itsf_status_asserts

bind itsf_status itsf_status_asserts u_chk (.clk(clk), .sys_rst(sys_rst),
	.ce(ce), .apb(apb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
	.evt(evt), .txLoad(txLoad), .ackEnable(ackEnable),
	.forceNack(forceNack), .toSlave(toSlave), .periphEnable(periphEnable));

// [tb/itsf_status_tb_top.sv]
// Self-checking bench for the status flag block
`timescale 1ns/1ps
module itsf_status_tb_top;
	import itsf_pkg::*;
	// ----
	// Harness
	// ----
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic go = 1'b0;
	logic [3:0] kind = 4'h0;
	logic [7:0] rxIn = 8'h00;
	itsf_apb_type apb = '0;
	itsf_line_type lines = '0;
	itsf_evt_type evt;
	logic [7:0] rxByte, txByte;
	logic [31:0] prdata;
	logic pready, pslverr, txLoad, ackEnable, forceNack, toSlave;
	logic periphEnable, errIrq, evIrq;
	logic [33:0] rdQ[$];
	logic [7:0] txQ[$];
	logic [33:0] mon;
	logic [2:0] r;
	int error_cnt = 0;
	int samples_checked = 0;
	int i;
	int ek[5] = '{11, 9, 8, 7, 6};
	int eb[5] = '{15, 12, 10, 8, 9};
	int vk[4] = '{0, 4, 2, 5};
	int vb[4] = '{0, 3, 1, 4};
	logic [7:0] va[4] = '{8'h10, 8'h10, 8'h18, 8'h00};
	logic [3:0] lm = 4'b0111;
	logic [3:0] vw = 4'b1011;
	always #10 clk = ~clk;
	// Short timeout keeps the run brief
	itsf_status #(.TIMEOUT_CYCLES(20)) uut (.clk(clk), .sys_rst(sys_rst),
		.ce(1'b1), .apb(apb), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .evt(evt), .lines(lines), .rxByte(rxByte),
		.txByte(txByte), .txLoad(txLoad), .ackEnable(ackEnable),
		.forceNack(forceNack), .toSlave(toSlave),
		.periphEnable(periphEnable), .errIrq(errIrq), .evIrq(evIrq));
	itsf_shift_model u_far (.clk(clk), .go(go), .kind(kind), .rxIn(rxIn),
		.evt(evt), .rxByte(rxByte));
	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
			error_cnt++;
		end
	endtask : chk
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test
	// One transfer; the read note is queued before setup
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic [33:0] e);
		int n = 0;
		if (!wr)
			rdQ.push_back(e);
		@(posedge clk);
		apb <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clk);
		apb.penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (!pready && n < 8);
		apb <= '0;
		if (!pready) begin
			error_cnt++;
			stop_test();
		end
	endtask : xfer
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0, {2'b00, e});
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 34'h0);
	endtask : wr
	// Ask the far side for one event pulse
	task automatic ev(input int k, input logic [7:0] b);
		@(posedge clk);
		go <= 1'b1;
		kind <= 4'(k);
		rxIn <= b;
		@(posedge clk);
		go <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : ev
	// Oldest note against each read answer whose note has bit 33 clear; oldest queued byte against each shifter load
	always @(posedge clk) begin
		if (pready && !apb.pwrite) begin
			mon = rdQ.pop_front();
			if (!mon[33])
				chk({pslverr, prdata}, mon[32:0]);
		end
		if (txLoad)
			chk({25'h0, txByte}, {25'h0, txQ.pop_front()});
	end
	// ----
	// Tests
	// ----
	initial begin
		r = 3'($urandom(32'h7027));
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		for (i = 0; i < 7; i++)
			xfer(1'b0, 8'(i * 4), 32'h0, {1'b0, (i == 2 || i == 3), 32'h0});
		lines <= {2'b00, r};
		repeat (2) @(posedge clk);
		rd(8'h18, {29'h0, r[1], r[0], r[2]});
		$display("reset test done");
		// Error flags: write 1 keeps, write 0 clears
		lines <= 5'b00100;
		wr(8'h00, 32'h0000000B);
		wr(8'h04, 32'h00000100);
		for (i = 0; i < 5; i++) begin
			ev(ek[i], 8'h00);
			rd(8'h14, 32'h1 << eb[i]);
			chk(errIrq, 1'b1);
			wr(8'h14, 32'hFFFF);
			rd(8'h14, 32'h1 << eb[i]);
			wr(8'h14, ~(32'h1 << eb[i]));
			rd(8'h14, 32'h0);
			chk(errIrq, 1'b0);
		end
		lines <= 5'b10000;
		repeat (30) @(posedge clk);
		lines <= 5'b00000;
		wr(8'h04, 32'h0);
		rd(8'h14, 32'h4000);
		chk(errIrq, 1'b0);
		wr(8'h14, 32'hBFFF);
		$display("error test done");
		// Receive with stretching, then without
		wr(8'h00, 32'h1);
		wr(8'h04, 32'h200);
		ev(12, 8'hA1);
		rd(8'h14, 32'h40);
		chk(evIrq, 1'b0);
		rd(8'h10, 32'hA1);
		rd(8'h14, 32'h0);
		ev(12, 8'hB2);
		ev(12, 8'hC3);
		rd(8'h14, 32'h44);
		chk(evIrq, 1'b1);
		rd(8'h10, 32'hB2);
		rd(8'h14, 32'h40);
		rd(8'h10, 32'hC3);
		wr(8'h00, 32'h81);
		ev(12, 8'h11);
		ev(12, 8'h22);
		rd(8'h14, 32'h840);
		wr(8'h14, 32'hF7FF);
		xfer(1'b0, 8'h10, 32'h0, {2'b10, 32'h0});
		rd(8'h14, 32'h0);
		$display("receive test done");
		// Transmit: direct load, queued byte, stall
		lines <= 5'b00110;
		wr(8'h00, 32'h1);
		txQ.push_back(8'h5C);
		wr(8'h10, 32'h5C);
		rd(8'h14, 32'h80);
		wr(8'h10, 32'h6D);
		rd(8'h14, 32'h0);
		txQ.push_back(8'h6D);
		ev(13, 8'h00);
		rd(8'h14, 32'h80);
		ev(13, 8'h00);
		rd(8'h14, 32'h84);
		ev(1, 8'h00);
		rd(8'h14, 32'h80);
		// No stretching, shifter drains with data register empty
		wr(8'h00, 32'h81);
		ev(13, 8'h00);
		rd(8'h14, 32'h880);
		wr(8'h14, 32'hF7FF);
		rd(8'h14, 32'h80);
		txQ.push_back(8'h7E);
		wr(8'h10, 32'h7E);
		wr(8'h10, 32'h0F);
		$display("transmit test done");
		// Event flags and their read-then-access clearing
		for (i = 0; i < 4; i++) begin
			lines <= {2'b00, lm[i], 2'b00};
			ev(vk[i], 8'h00);
			rd(8'h14, 32'h1 << vb[i]);
			xfer(vw[i], va[i], 32'h1, {2'b10, 32'h0});
			rd(8'h14, 32'h0);
		end
		$display("event test done");
		stop_test();
	end
endmodule : itsf_status_tb_top
